// File: include/teg_pkg.sv
/*
 Shared constants of the tear output generator: command codes, parameter
 field positions, reset values and default display geometry.
 Assumes a command decoder upstream that presents one command code and one
 parameter byte at a time on the display timing clock.
*/
package teg_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_TEAR_OFF    = 8'h34;
    localparam logic [7:0] CMD_TEAR_ON     = 8'h35;
    localparam logic [7:0] CMD_LINE_HIGH   = 8'h44;
    localparam logic [7:0] CMD_LINE_LOW    = 8'h45;
    localparam logic [7:0] CMD_READ_LINE   = 8'h46;
    // ==========================================================
    // Tear enable config fields
    localparam int         CFG_MODE_BIT    = 0;
    localparam int         CFG_POL_BIT     = 1;
    localparam int         CFG_WIDTH_LSB   = 4;
    localparam int         CFG_WIDTH_MSB   = 7;
    localparam logic [7:0] CFG_RESET       = 8'h00;
    // ==========================================================
    // Target line fields
    localparam int         LINE_W          = 11;
    localparam int         HI_LSB          = 1;
    localparam int         HI_MSB          = 3;
    localparam int         LO_LSB          = 1;
    localparam int         LO_MSB          = 7;
    localparam int         LO_BIT7_POS     = 0;
    localparam logic [7:0] LINE_RESET      = 8'h00;
    // ==========================================================
    // Default geometry, in clocks and lines
    localparam int         DEF_H_ACTIVE    = 16;
    localparam int         DEF_H_PORCH     = 4;
    localparam int         DEF_V_ACTIVE    = 1920;
    localparam int         DEF_V_PORCH     = 8;
    localparam int         CNT_W           = 16;
endpackage

// File: rtl/teg_timing.sv
/*
 Display raster counter: pixel clocks within a line and lines within a
 frame, with porch flags and a one-cycle frame start pulse.
 Assumes a single clock; geometry is fixed by parameters.
*/
module teg_timing #(
    parameter int H_ACTIVE = teg_pkg::DEF_H_ACTIVE,
    parameter int H_PORCH  = teg_pkg::DEF_H_PORCH,
    parameter int V_ACTIVE = teg_pkg::DEF_V_ACTIVE,
    parameter int V_PORCH  = teg_pkg::DEF_V_PORCH
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    output logic [teg_pkg::CNT_W-1:0]     pix_reg,
    output logic [teg_pkg::CNT_W-1:0]     line_reg,
    output logic                          line_start,
    output logic                          frame_start,
    output logic                          h_porch,
    output logic                          v_porch
);
    localparam logic [teg_pkg::CNT_W-1:0] H_LAST =
        teg_pkg::CNT_W'(H_ACTIVE + H_PORCH - 1);
    localparam logic [teg_pkg::CNT_W-1:0] V_LAST =
        teg_pkg::CNT_W'(V_ACTIVE + V_PORCH - 1);
    localparam logic [teg_pkg::CNT_W-1:0] H_ACT  =
        teg_pkg::CNT_W'(H_ACTIVE);
    localparam logic [teg_pkg::CNT_W-1:0] V_PRCH =
        teg_pkg::CNT_W'(V_PORCH);

    // Lines 0..V_PORCH-1 are vertical porch, then the active lines
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pix_reg  <= '0;
            line_reg <= '0;
        end else if (pix_reg == H_LAST) begin
            pix_reg  <= '0;
            line_reg <= (line_reg == V_LAST) ? '0 : line_reg + 1'b1;
        end else begin
            pix_reg  <= pix_reg + 1'b1;
        end
    end

    assign line_start  = (pix_reg == '0);
    assign frame_start = line_start && (line_reg == '0);
    assign h_porch     = (pix_reg >= H_ACT);
    assign v_porch     = (line_reg < V_PRCH);
endmodule

// File: rtl/teg_top.sv
/*
 Tear output generator: holds tear configuration and target line set by
 display commands, produces the frame sync output and returns the current
 scan line on a read command.
 Assumes the command decoder gives cmd_valid/param_valid pulses on clk and
 that the host reads both scan line bytes.
*/
// Behaviour
// [RULE1] Mode 0, line 0: active in vertical porch
// [RULE2] Mode 1: active in all porches
// [RULE3] Mode 0, nonzero line: active at line
// [RULE4] Polarity 0 high, 1 low
// [RULE5] Width field plus one lines active
// [RULE6] Repeated enable leaves output unchanged
// [RULE7] Line refresh order never affects output
// [RULE8] Sleep holds output low
// [RULE9] Target line assembled from two bytes
// [RULE10] Line value plus one selects line
// [RULE11] New settings apply from next frame
// [RULE12] Registers reset to zero
// [RULE13] Scan line read MSB first, two bytes
// [RULE14] Host issues commands only when allowed
// [RULE15] Tear off holds output low
// [RULE16] Width counted in lines from assertion
module teg_top #(
    parameter int H_ACTIVE = teg_pkg::DEF_H_ACTIVE,
    parameter int H_PORCH  = teg_pkg::DEF_H_PORCH,
    parameter int V_ACTIVE = teg_pkg::DEF_V_ACTIVE,
    parameter int V_PORCH  = teg_pkg::DEF_V_PORCH
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        param_valid,
    input  wire logic [7:0]  param_data,
    input  wire logic        rd_req,
    input  wire logic        sleep_in,
    input  wire logic        line_refresh_order,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             frame_sync_output,
    output logic [7:0]       cfg_readback
);
    localparam int LW = teg_pkg::LINE_W;
    localparam int CW = teg_pkg::CNT_W;

    // ==========================================================
    // Raster timing
    logic [CW-1:0] pix_cnt;
    logic [CW-1:0] line_cnt;
    logic          line_start;
    logic          h_porch;
    logic          v_porch;

    teg_timing #(
        .H_ACTIVE (H_ACTIVE),
        .H_PORCH  (H_PORCH),
        .V_ACTIVE (V_ACTIVE),
        .V_PORCH  (V_PORCH)
    ) teg_timing_inst (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .pix_reg     (pix_cnt),
        .line_reg    (line_cnt),
        .line_start  (line_start),
        .frame_start (),
        .h_porch     (h_porch),
        .v_porch     (v_porch)
    );

    // ==========================================================
    // Command decode
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CFG,
        ST_HIGH,
        ST_LOW,
        ST_RD_HI,
        ST_RD_LO
    } teg_state_t;

    teg_state_t  state_reg;
    logic [7:0]  cfg_reg;
    logic [7:0]  line_hi_reg;
    logic [7:0]  line_lo_reg;
    logic        enable_reg;
    logic [15:0] scan_snap_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else if (cmd_valid) begin
            case (cmd_code)
                teg_pkg::CMD_TEAR_ON:   state_reg <= ST_CFG;
                teg_pkg::CMD_LINE_HIGH: state_reg <= ST_HIGH;
                teg_pkg::CMD_READ_LINE: state_reg <= ST_RD_HI;
                default:                state_reg <= ST_IDLE;
            endcase
        end else begin
            case (state_reg)
                ST_CFG:   if (param_valid) state_reg <= ST_IDLE;
                ST_HIGH:  if (param_valid) state_reg <= ST_LOW;
                ST_LOW:   if (param_valid) state_reg <= ST_IDLE;
                ST_RD_HI: if (rd_req) state_reg <= ST_RD_LO;
                ST_RD_LO: if (rd_req) state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // Shadow registers; written any time, sampled on the last clock of the frame (frame_end)
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg     <= teg_pkg::CFG_RESET; // [RULE12]
            line_hi_reg <= teg_pkg::LINE_RESET; // [RULE12]
            line_lo_reg <= teg_pkg::LINE_RESET; // [RULE12]
        end else if (param_valid && !cmd_valid) begin
            if (state_reg == ST_CFG)
                cfg_reg <= param_data;
            if (state_reg == ST_HIGH)
                line_hi_reg <= param_data;
            if (state_reg == ST_LOW)
                line_lo_reg <= param_data;
        end
    end

    // Repeated enable simply keeps the flag set
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_reg <= 1'b0;
        end else if (cmd_valid && cmd_code == teg_pkg::CMD_TEAR_OFF) begin
            enable_reg <= 1'b0; // [RULE15]
        end else if (cmd_valid && cmd_code == teg_pkg::CMD_TEAR_ON) begin
            enable_reg <= 1'b1; // [RULE6]
        end
    end

    // Snapshot so both bytes belong to the same line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_snap_reg <= '0;
            rd_data       <= '0;
            rd_valid      <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (cmd_valid && cmd_code == teg_pkg::CMD_READ_LINE)
                scan_snap_reg <= line_cnt;
            if (rd_req && state_reg == ST_RD_HI) begin
                rd_data  <= scan_snap_reg[15:8]; // [RULE13]
                rd_valid <= 1'b1;
            end else if (rd_req && state_reg == ST_RD_LO) begin
                rd_data  <= scan_snap_reg[7:0]; // [RULE13]
                rd_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            cfg_readback <= teg_pkg::CFG_RESET;
        else
            cfg_readback <= cfg_reg;
    end

    // ==========================================================
    // Frame-latched settings
    logic [LW-1:0] target_line;
    logic [LW-1:0] act_line_reg;
    logic          act_mode_reg;
    logic          act_pol_reg;
    logic [3:0]    act_width_reg;
    logic          act_en_reg;

    assign target_line = {line_hi_reg[teg_pkg::HI_MSB:teg_pkg::HI_LSB],
                          line_lo_reg[teg_pkg::LO_BIT7_POS],
                          line_lo_reg[teg_pkg::LO_MSB:teg_pkg::LO_LSB]};
                          // [RULE9]

    // Latch on the last clock so line 0 already runs the new values
    localparam logic [CW-1:0] PIX_LAST  = CW'(H_ACTIVE + H_PORCH - 1);
    localparam logic [CW-1:0] LINE_LAST = CW'(V_ACTIVE + V_PORCH - 1);
    logic          frame_end;

    assign frame_end = (pix_cnt == PIX_LAST) && (line_cnt == LINE_LAST);

    // Current frame keeps old values until its end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_line_reg  <= '0;
            act_mode_reg  <= 1'b0;
            act_pol_reg   <= 1'b0;
            act_width_reg <= '0;
            act_en_reg    <= 1'b0;
        end else if (frame_end) begin // [RULE11]
            act_line_reg  <= target_line;
            act_mode_reg  <= cfg_reg[teg_pkg::CFG_MODE_BIT];
            act_pol_reg   <= cfg_reg[teg_pkg::CFG_POL_BIT];
            act_width_reg <=
                cfg_reg[teg_pkg::CFG_WIDTH_MSB:teg_pkg::CFG_WIDTH_LSB];
            act_en_reg    <= enable_reg;
        end
    end

    // ==========================================================
    // Pulse generation
    // Line refresh order is deliberately unused: scan counter only
    logic [4:0]    lines_left_reg;
    logic          trig_line;
    logic          line_pulse;
    logic          raw_active;
    logic [CW-1:0] trig_idx;

    // Value 0 is porch start; nonzero N selects raster index N + V_PORCH
    assign trig_idx   = CW'(act_line_reg) + CW'(V_PORCH); // [RULE10]
    assign trig_line  = (act_line_reg == '0) ? (line_cnt == '0) // [RULE7]
                                             : (line_cnt == trig_idx);
    assign line_pulse = (lines_left_reg != '0);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lines_left_reg <= '0;
        end else if (line_start) begin
            if (trig_line && !act_mode_reg)
                lines_left_reg <= {1'b0, act_width_reg} + 5'd1; // [RULE16]
            else if (line_pulse)
                lines_left_reg <= lines_left_reg - 5'd1; // [RULE5]
        end
    end

    always_comb begin
        if (act_mode_reg)
            raw_active = v_porch || h_porch; // [RULE2]
        else if (act_line_reg == '0)
            raw_active = v_porch && line_pulse; // [RULE1]
        else
            raw_active = line_pulse; // [RULE3]
    end

    // Pulse counter updates at line_start, so drop the stale first pixel
    logic          pulse_now;
    assign pulse_now = act_mode_reg ? raw_active
                     : ((line_start && trig_line) ||
                        (raw_active &&
                         !(line_start && lines_left_reg == 5'd1)));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            frame_sync_output <= 1'b0;
        else if (sleep_in || !act_en_reg || !enable_reg)
            frame_sync_output <= 1'b0; // [RULE8] [RULE15]
        else
            frame_sync_output <= pulse_now ^ act_pol_reg; // [RULE4]
    end
endmodule

// File: testbench/teg_top_chk.sv
/*
 Port checker for the tear output generator, bound into teg_top.
 Assumes one clock domain with sys_rst as its asynchronous reset.
*/
module teg_top_chk (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic       rd_req,
    input wire logic       sleep_in,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       frame_sync_output,
    input wire logic [7:0] cfg_readback
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       off_reg;
    logic [1:0] rd_left;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Shadow of the enable gate and of pending read bytes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            off_reg <= 1'h1;
        else if (cmd_valid && cmd_code == teg_pkg::CMD_TEAR_OFF)
            off_reg <= 1'h1;
        else if (cmd_valid && cmd_code == teg_pkg::CMD_TEAR_ON)
            off_reg <= 1'h0;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            rd_left <= 2'h0;
        else if (cmd_valid)
            rd_left <= (cmd_code == teg_pkg::CMD_READ_LINE) ? 2'h2 : 2'h0;
        else if (rd_req && rd_left != 2'h0)
            rd_left <= rd_left - 2'h1;
    end
    // ==========================================================
    // Properties
    property p_rst;
        $past(sys_rst) |-> !frame_sync_output && !rd_valid
            && cfg_readback == 8'h00;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not clear after reset");
    property p_sleep;
        sleep_in ##1 sleep_in |-> !frame_sync_output;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("tear output not low in sleep");
    property p_off;
        off_reg && $past(off_reg) && $past(off_reg, 2) |-> !frame_sync_output;
    endproperty
    a_off: assert property (p_off)
        else $error("tear output active while off");
    property p_run;
        $rose(frame_sync_output) && !cmd_valid && !$past(cmd_valid)
            && !$past(cmd_valid, 2) && !sleep_in && !$past(sleep_in, 2)
            |=> frame_sync_output;
    endproperty
    a_run: assert property (p_run)
        else $error("tear pulse shorter than two clocks");
    property p_rd_ans;
        rd_req && rd_left != 2'h0 |=> rd_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read byte not answered");
    property p_rdv_cause;
        rd_valid |-> $past(rd_req);
    endproperty
    a_rdv_cause: assert property (p_rdv_cause)
        else $error("read valid without request");
    property p_rdv_pulse;
        rd_valid && !rd_req |=> !rd_valid;
    endproperty
    a_rdv_pulse: assert property (p_rdv_pulse)
        else $error("read valid longer than one cycle");
    property p_rdd_hold;
        !rd_valid |-> $stable(rd_data);
    endproperty
    a_rdd_hold: assert property (p_rdd_hold)
        else $error("read data changed without valid");
endmodule

bind teg_top teg_top_chk teg_top_chk_inst (.clk, .sys_rst, .cmd_valid,
    .cmd_code, .rd_req, .sleep_in, .rd_data, .rd_valid,
    .frame_sync_output, .cfg_readback);

// File: testbench/teg_host.sv
/*
 Host model: issues display commands, parameters and scan line reads.
 Assumes the caller is the testbench and inputs change at falling edges.
*/
module teg_host (
    input  wire logic       clk,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic            param_valid,
    output logic [7:0]      param_data,
    output logic            rd_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'h0;
        cmd_code = 8'h00;
        param_valid = 1'h0;
        param_data = 8'h00;
        rd_req = 1'h0;
    end
    // ==========================================================
    // Only commands of the normal, idle-off state are issued
    task automatic cmd(input logic [7:0] code, input int n,
                       input logic [7:0] b0, input logic [7:0] b1);
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_code = code;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            cmd_valid = 1'h0;
            param_valid = 1'h1;
            param_data = (i == 0) ? b0 : b1;
        end
        @(negedge clk);
        cmd_valid = 1'h0;
        param_valid = 1'h0;
        // Stale bus would hide a late sample
        cmd_code = ~code;
        param_data = ~param_data;
    endtask
    task automatic read_line(output logic [15:0] v);
        cmd(teg_pkg::CMD_READ_LINE, 0, 8'h00, 8'h00);
        for (int i = 0; i < 2; i++) begin
            rd_req = 1'h1;
            @(negedge clk);
            rd_req = 1'h0;
            v = {v[7:0], (rd_valid === 1'h1) ? rd_data : 8'hxx};
            @(negedge clk);
        end
    endtask
endmodule

// File: testbench/test_tear_effect_output_gen.sv
/*
 Self-checking bench for teg_top: counts active clocks per frame.
 Assumes a shortened raster so a frame is a few dozen clocks.
*/
module test_tear_effect_output_gen;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HA = 4;
    localparam int HP = 2;
    localparam int VA = 8;
    localparam int VP = 4;
    localparam int LN = HA + HP;
    localparam int FRAME = LN * (VA + VP);
    logic       clk = 1'h0;
    logic       sys_rst = 1'h1;
    logic       sleep_in = 1'h0;
    logic       line_refresh_order = 1'h0;
    logic       cmd_valid, param_valid, rd_req, rd_valid;
    logic       frame_sync_output;
    logic [7:0] cmd_code, param_data, rd_data, cfg_readback;
    int         miscompares = 0;
    int         n_compared = 0;
    always #10 clk = ~clk;
    teg_host teg_host_inst (.clk(clk), .rd_valid(rd_valid),
        .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .param_valid(param_valid), .param_data(param_data), .rd_req(rd_req));
    teg_top #(.H_ACTIVE(HA), .H_PORCH(HP), .V_ACTIVE(VA), .V_PORCH(VP))
    teg_top_inst (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .param_valid(param_valid),
        .param_data(param_data), .rd_req(rd_req), .sleep_in(sleep_in),
        .line_refresh_order(line_refresh_order), .rd_data(rd_data),
        .rd_valid(rd_valid), .frame_sync_output(frame_sync_output),
        .cfg_readback(cfg_readback));
    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask
    // Any whole-frame window gives the same count
    task automatic count_hi(output logic [15:0] n);
        n = 16'h0000;
        repeat (FRAME) begin
            @(negedge clk);
            n = n + {15'h0000, frame_sync_output === 1'h1};
        end
    endtask
    task automatic run(input logic [7:0] cfg, input logic [7:0] hi,
                       input logic [7:0] lo, input int exp);
        logic [15:0] n;
        teg_host_inst.cmd(teg_pkg::CMD_LINE_HIGH, 2, hi, lo);
        teg_host_inst.cmd(teg_pkg::CMD_TEAR_ON, 1, cfg, 8'h00);
        repeat (2 * FRAME) @(negedge clk);
        count_hi(n);
        check(n, exp[15:0]);
        $display("test cfg %h line %h %h done", cfg, hi, lo);
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        logic [15:0] v;
        repeat (3) @(negedge clk);
        sys_rst = 1'h0;
        check({8'h00, cfg_readback}, 16'h0000);
        count_hi(v);
        check(v, 16'h0000);
        $display("test reset done");
        run(8'h10, 8'h00, 8'h00, 2 * LN);
        run(8'hf0, 8'h00, 8'h00, VP * LN);
        run(8'h01, 8'h00, 8'h04, VP * LN + VA * HP);
        run(8'h20, 8'h00, 8'h04, 3 * LN);
        run(8'h20, 8'h02, 8'h00, 0);
        run(8'h20, 8'h00, 8'h01, 0);
        run(8'h12, 8'h00, 8'h00, FRAME - 2 * LN);
        sleep_in = 1'h1;
        count_hi(v);
        count_hi(v);
        check(v, 16'h0000);
        $display("test sleep done");
        sleep_in = 1'h0;
        line_refresh_order = 1'h1;
        run(8'h10, 8'h00, 8'h00, 2 * LN);
        run(8'h10, 8'h00, 8'h00, 2 * LN);
        @(posedge frame_sync_output);
        fork
            count_hi(v);
            teg_host_inst.cmd(teg_pkg::CMD_TEAR_ON, 1, 8'hf0, 8'h00);
        join
        check(v, 16'(2 * LN));
        count_hi(v);
        check(v, 16'(VP * LN));
        $display("test next frame done");
        teg_host_inst.read_line(v);
        check({8'h00, v[15:8]}, 16'h0000);
        check({15'h0000, v < 16'(VA + VP)}, 16'h0001);
        $display("test scan line done");
        teg_host_inst.cmd(teg_pkg::CMD_TEAR_OFF, 0, 8'h00, 8'h00);
        count_hi(v);
        check(v, 16'h0000);
        $display("test tear off done");
        finish_test();
    end
    initial begin
        repeat (60 * FRAME) @(posedge clk);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
